// File: flow_wake_params.svh
// constants for the host flow control and wake-up control block
// assumes inclusion by bare name from the top module and the bench
`ifndef FLOW_WAKE_PARAMS_SVH
`define FLOW_WAKE_PARAMS_SVH

// --------------------------------------------------------------
// register byte offsets on the wishbone slave
// --------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_THRESHOLD 8'h04
`define REG_GOOD_COUNT 8'h08
`define REG_HOP 8'h0c
`define REG_IDLE_INIT 8'h10
`define REG_INIT_DUR 8'h14
`define REG_SLEEP_TO 8'h18
`define REG_SLEEP_INT 8'h1c
`define REG_STATUS 8'h20

// --------------------------------------------------------------
// control field positions
// --------------------------------------------------------------
`define CTRL_SOFT_FLOW 0
`define CTRL_FORCE_INIT 1
`define CTRL_SLEEP_SEL 2

// --------------------------------------------------------------
// serial command codes of the parameters held here
// --------------------------------------------------------------
`define CMD_FORCE_INIT 8'h0d
`define CMD_SOFT_FLOW 8'h07
`define CMD_THRESHOLD 8'h24
`define CMD_GOOD_COUNT 8'h10
`define CMD_HOP 8'h11
`define CMD_IDLE_INIT 8'h03
`define CMD_INIT_DUR 8'h0c

// --------------------------------------------------------------
// flow characters, limits and reset values
// --------------------------------------------------------------
`define XON_CHAR 8'h11
`define XOFF_CHAR 8'h13
`define FLOW_MARGIN 8'h11
`define RX_OUT_BUF_SIZE 8'hff
`define THRESHOLD_MAX (`RX_OUT_BUF_SIZE - `FLOW_MARGIN)
`define HOP_MAX 3'h6
`define HOP_RESET 3'h0
`define IDLE_INIT_RESET 16'hffff
`define IDLE_INIT_OFF 16'hffff
`define INIT_DUR_RESET 8'h01
`define SLEEP_TO_RESET 16'h0014
`define SLEEP_INT_RESET 8'h00
`define COUNT_MAX 16'hffff

// --------------------------------------------------------------
// timing: clock rate and times in their own units
// --------------------------------------------------------------
`define CLK_KHZ 50000
`define TICK_MS 100
`define DETECT_MS 35
`define LISTEN_MS 70
`define TICK_CYCLES (`TICK_MS * `CLK_KHZ)
`define DETECT_CYCLES (`DETECT_MS * `CLK_KHZ)
`define LISTEN_CYCLES (`LISTEN_MS * `CLK_KHZ)

`endif

// File: flow_wake_pkg.sv
// types shared by the flow control and wake-up control block
// uses no macros from the params header, so needs no include path
package flow_wake_pkg;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_stream_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // --------------------------------------------------------------
  // receiver sleep states
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_AWAKE,
    RX_SLEEPING,
    RX_LISTENING
  } sleep_state_t;

  // --------------------------------------------------------------
  // whole state of the control block
  // --------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic soft_flow_enable;
    logic init_pending;
    logic sleep_select;
    logic [7:0] flow_threshold;
    logic [15:0] good_packet_count;
    logic [2:0] hop_channel;
    logic [15:0] idle_before_initializer;
    logic [7:0] initializer_duration;
    logic [15:0] sleep_inactivity_timeout;
    logic [7:0] sleep_interval;
    logic xoff_sent;
    logic flow_req;
    logic [7:0] flow_char;
    logic [23:0] tick_cnt;
    logic [15:0] idle_ticks;
    logic sending_init;
    logic [8:0] init_ticks;
    sleep_state_t rx_state;
    logic [7:0] nap_ticks;
    logic [23:0] detect_cnt;
    logic [23:0] listen_cnt;
  } ctrl_state_t;

endpackage : flow_wake_pkg

// File: byte_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  // fill level
  output logic [AW:0] count_o
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic push;
  logic pop;

  // handshakes straight from the fill count
  assign in_ready_o = (s.count != (AW+1)'(DEPTH));
  assign out_valid_o = (s.count != '0);
  assign out_data_o = s.mem[s.rd];
  assign count_o = s.count;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // pointer wrap assumes a power-of-two depth
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data_i;
      next_s.wr = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : byte_fifo

// File: host_flow_and_wakeup_control.sv
// serial flow control, good packet count, hop channel and wake-up
// initializer timing of the radio module, with a wishbone slave
// assumes serial and radio strobes come from logic on clk_i
//
// Behaviour
// [RULE1] force command makes the next transmission carry an initializer
// [RULE2] clear-to-send tells the host when it may send serial bytes
// [RULE3] software flow setting is 0 off or 1 on, reset 0
// [RULE4] software flow uses 0x11 to resume and 0x13 to stop
// [RULE5] fill reaching threshold drops clear-to-send or sends stop char
// [RULE6] threshold accepts zero to buffer size minus 0x11, its default
// [RULE7] good packet count is readable, writable and cleared by reset
// [RULE8] good packet count saturates at maximum until written or reset
// [RULE9] hop channel 0 to 6, default 0; only same-channel peers count
// [RULE10] idle time in 100 ms units reached arms a long initializer
// [RULE11] idle setting defaults to 0xffff which disables long initializer
// [RULE12] configurer should match idle setting to receivers sleep timeout
// [RULE13] sleeping receiver wakes each interval and stays up on detection
// [RULE14] initializer lasts longer than the cyclic sleep interval
// [RULE15] good packet count is command 0x10, two bytes, default zero
// [RULE16] idle setting is command 0x03, range 0 to 0xffff, two bytes
// [RULE17] receiver stays awake only after about 35 ms of initializer
// [RULE18] flow is released once fill drops below the threshold
`timescale 1ns/100ps
`include "flow_wake_params.svh"
module host_flow_and_wakeup_control #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int DETECT_CYCLES = `DETECT_CYCLES,
  parameter int LISTEN_CYCLES = `LISTEN_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire flow_wake_pkg::wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial input from the host receiver
  input wire flow_wake_pkg::byte_stream_t serial_input_i,
  output logic serial_input_ready_o,
  output logic clear_to_send_pin_o,
  // flow characters toward the host transmitter
  output flow_wake_pkg::byte_stream_t flow_char_o,
  input wire logic flow_char_ready_i,
  // buffered data toward the radio
  output flow_wake_pkg::byte_stream_t radio_data_o,
  input wire logic radio_data_ready_i,
  // radio transmit side
  input wire logic tx_start_i,
  input wire logic tx_active_i,
  output logic initializer_send_o,
  // radio receive side
  input wire logic rx_activity_i,
  input wire logic rx_good_i,
  input wire logic [2:0] rx_channel_i,
  input wire logic initializer_detect_i,
  output logic rx_accept_o,
  output logic [2:0] hop_channel_o,
  output logic radio_awake_o
);

  import flow_wake_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wdat[15:8];
    end
    return r;
  endfunction : merge16

  // saturating increment of a 16-bit count
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == `COUNT_MAX) ? v : v + 16'h0001;
  endfunction : sat_inc

  // ----------------------------------------------------------------
  // state and fifo
  // ----------------------------------------------------------------
  ctrl_state_t s;
  ctrl_state_t next_s;
  logic [2:0] fill;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic over;
  logic take;
  logic wr;
  logic tick;
  logic activity;
  logic long_due;
  logic [8:0] init_len;
  logic [15:0] wval;

  // four-byte buffer between host serial input and the radio
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(4)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(serial_input_i.valid),
    .in_data_i(serial_input_i.data),
    .in_ready_o(serial_input_ready_o),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(radio_data_ready_i),
    .count_o(fill)
  );

  // ----------------------------------------------------------------
  // combinational terms
  // ----------------------------------------------------------------
  assign over = ({5'h00, fill} >= s.flow_threshold); // [RULE5]
  assign take = wb_req_i.cyc & wb_req_i.stb & ~s.ack;
  assign wr = take & wb_req_i.we;
  assign tick = (s.tick_cnt == 24'(TICK_CYCLES - 1));

  // a wake-up counts as activity so sleep timing restarts
  assign activity = tx_active_i | rx_activity_i | s.sending_init
                    | (s.rx_state != RX_AWAKE);
  assign long_due = (s.idle_before_initializer != `IDLE_INIT_OFF) &&
                    (s.idle_ticks >= s.idle_before_initializer); // [RULE11]

  // initializer always one tick past the sleep interval at least
  assign init_len = ({1'b0, s.initializer_duration} > {1'b0, s.sleep_interval})
                    ? {1'b0, s.initializer_duration}
                    : {1'b0, s.sleep_interval} + 9'h001; // [RULE14]
  assign wval = merge16(16'h0000, wb_req_i.dat, wb_req_i.sel);

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  // in software mode the pin stays open and characters do the work
  assign clear_to_send_pin_o = s.soft_flow_enable | ~over; // [RULE2]
  assign flow_char_o.valid = s.flow_req;
  assign flow_char_o.data = s.flow_char;
  assign radio_data_o.valid = fifo_out_valid;
  assign radio_data_o.data = fifo_out_data;
  assign initializer_send_o = s.sending_init;
  assign rx_accept_o = (rx_channel_i == s.hop_channel); // [RULE9]
  assign hop_channel_o = s.hop_channel;
  assign radio_awake_o = (s.rx_state != RX_SLEEPING);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // bus answer: one wait state, dropped the cycle after
    next_s.ack = take;
    if (take) begin
      next_s.rdata = 32'h0000_0000;
      unique case (wb_req_i.adr)
        `REG_CTRL: begin
          next_s.rdata[`CTRL_SOFT_FLOW] = s.soft_flow_enable;
          next_s.rdata[`CTRL_FORCE_INIT] = s.init_pending;
          next_s.rdata[`CTRL_SLEEP_SEL] = s.sleep_select;
        end
        `REG_THRESHOLD: next_s.rdata[7:0] = s.flow_threshold;
        `REG_GOOD_COUNT: next_s.rdata[15:0] = s.good_packet_count; // [RULE15]
        `REG_HOP: next_s.rdata[2:0] = s.hop_channel;
        `REG_IDLE_INIT: next_s.rdata[15:0] = s.idle_before_initializer;
        `REG_INIT_DUR: next_s.rdata[7:0] = s.initializer_duration;
        `REG_SLEEP_TO: next_s.rdata[15:0] = s.sleep_inactivity_timeout;
        `REG_SLEEP_INT: next_s.rdata[7:0] = s.sleep_interval;
        `REG_STATUS: begin
          next_s.rdata[0] = clear_to_send_pin_o;
          next_s.rdata[1] = s.xoff_sent;
          next_s.rdata[2] = s.sending_init;
          next_s.rdata[3] = radio_awake_o;
          next_s.rdata[6:4] = fill;
          next_s.rdata[9:8] = s.rx_state;
        end
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // good packet count from matching peers only
    if (rx_good_i && rx_accept_o) begin
      next_s.good_packet_count = sat_inc(s.good_packet_count); // [RULE8]
    end

    // 100 ms prescaler and idle timer
    next_s.tick_cnt = tick ? 24'h000000 : s.tick_cnt + 24'h000001;
    if (activity) begin
      next_s.idle_ticks = 16'h0000;
    end else if (tick) begin
      next_s.idle_ticks = sat_inc(s.idle_ticks); // [RULE10]
    end

    // long initializer: armed by idle time or force, spent at tx start
    if (s.sending_init) begin
      if (tick) begin
        next_s.init_ticks = s.init_ticks + 9'h001;
      end
      if (s.init_ticks >= init_len) begin
        next_s.sending_init = 1'b0; // [RULE14]
      end
    end else if (tx_start_i && (s.init_pending || long_due)) begin
      next_s.sending_init = 1'b1; // [RULE10]
      next_s.init_ticks = 9'h000;
      next_s.init_pending = 1'b0;
    end

    // software flow: stop once at threshold, resume once below
    if (s.flow_req) begin
      if (flow_char_ready_i) begin
        next_s.flow_req = 1'b0;
      end
    end else if (over && s.soft_flow_enable && !s.xoff_sent) begin
      next_s.flow_req = 1'b1;
      next_s.flow_char = `XOFF_CHAR; // [RULE4]
      next_s.xoff_sent = 1'b1; // [RULE5]
    end else if (!over && s.xoff_sent) begin
      next_s.flow_req = 1'b1;
      next_s.flow_char = `XON_CHAR; // [RULE4]
      next_s.xoff_sent = 1'b0; // [RULE18]
    end

    // receiver cyclic sleep
    unique case (s.rx_state)
      RX_AWAKE: begin
        if (s.sleep_select &&
            s.idle_ticks >= s.sleep_inactivity_timeout) begin
          next_s.rx_state = RX_SLEEPING;
          next_s.nap_ticks = 8'h00;
        end
      end
      RX_SLEEPING: begin
        if (tick) begin
          next_s.nap_ticks = s.nap_ticks + 8'h01;
        end
        if (s.nap_ticks >= s.sleep_interval) begin
          next_s.rx_state = RX_LISTENING; // [RULE13]
          next_s.detect_cnt = 24'h000000;
          next_s.listen_cnt = 24'h000000;
        end
      end
      RX_LISTENING: begin
        next_s.listen_cnt = s.listen_cnt + 24'h000001;
        next_s.detect_cnt = initializer_detect_i
                            ? s.detect_cnt + 24'h000001 : 24'h000000;
        // this cycle included
        if (next_s.detect_cnt >= 24'(DETECT_CYCLES)) begin
          next_s.rx_state = RX_AWAKE; // [RULE17]
        end else if (s.listen_cnt >= 24'(LISTEN_CYCLES - 1)) begin
          next_s.rx_state = RX_SLEEPING;
          next_s.nap_ticks = 8'h00;
        end
      end
    endcase
    if (!s.sleep_select) begin
      next_s.rx_state = RX_AWAKE;
    end

    // register writes at the edge the answer rises
    if (wr) begin
      unique case (wb_req_i.adr)
        `REG_CTRL: begin
          if (wb_req_i.sel[0]) begin
            next_s.soft_flow_enable = wb_req_i.dat[`CTRL_SOFT_FLOW]; // [RULE3]
            next_s.sleep_select = wb_req_i.dat[`CTRL_SLEEP_SEL];
            // set wins over a same-cycle clear by tx start
            if (wb_req_i.dat[`CTRL_FORCE_INIT]) begin
              next_s.init_pending = 1'b1; // [RULE1]
            end
          end
        end
        `REG_THRESHOLD: begin
          // out-of-range values are dropped, old value kept
          if (wb_req_i.sel[0] && wb_req_i.dat[7:0] <= `THRESHOLD_MAX) begin
            next_s.flow_threshold = wb_req_i.dat[7:0]; // [RULE6]
          end
        end
        `REG_GOOD_COUNT: begin
          next_s.good_packet_count = merge16(s.good_packet_count,
                                             wb_req_i.dat,
                                             wb_req_i.sel); // [RULE7]
        end
        `REG_HOP: begin
          if (wb_req_i.sel[0] && wb_req_i.dat[7:0] <= {5'h00, `HOP_MAX}) begin
            next_s.hop_channel = wb_req_i.dat[2:0]; // [RULE9]
          end
        end
        `REG_IDLE_INIT: begin
          next_s.idle_before_initializer = merge16(s.idle_before_initializer,
                                                   wb_req_i.dat,
                                                   wb_req_i.sel); // [RULE16]
        end
        `REG_INIT_DUR: begin
          if (wb_req_i.sel[0]) begin
            next_s.initializer_duration = wval[7:0];
          end
        end
        `REG_SLEEP_TO: begin
          next_s.sleep_inactivity_timeout = merge16(
            s.sleep_inactivity_timeout, wb_req_i.dat, wb_req_i.sel);
        end
        `REG_SLEEP_INT: begin
          if (wb_req_i.sel[0]) begin
            next_s.sleep_interval = wval[7:0];
          end
        end
        default: next_s.ack = take;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register, reset values here
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.flow_threshold <= `THRESHOLD_MAX; // [RULE6]
      s.good_packet_count <= 16'h0000; // [RULE7]
      s.hop_channel <= `HOP_RESET;
      s.idle_before_initializer <= `IDLE_INIT_RESET; // [RULE11]
      s.initializer_duration <= `INIT_DUR_RESET;
      s.sleep_inactivity_timeout <= `SLEEP_TO_RESET;
      s.sleep_interval <= `SLEEP_INT_RESET;
      s.rx_state <= RX_AWAKE;
    end else begin
      s <= next_s;
    end
  end

endmodule : host_flow_and_wakeup_control

// File: host_flow_monitor.sv
// checker of the flow and wake-up block, bound to its top module
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module host_flow_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire flow_wake_pkg::wb_req_t wb_req_i,
  input wire logic wb_ack_o,
  // streams
  input wire flow_wake_pkg::byte_stream_t flow_char_o,
  input wire logic flow_char_ready_i,
  input wire flow_wake_pkg::byte_stream_t radio_data_o,
  input wire logic radio_data_ready_i,
  // radio
  input wire logic tx_start_i,
  input wire logic initializer_send_o,
  input wire logic [2:0] rx_channel_i,
  input wire logic rx_accept_o,
  input wire logic [2:0] hop_channel_o
);
  import flow_wake_pkg::*;
  // ----
  // assertions
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_latency_a: assert property (wb_req_i.cyc && wb_req_i.stb
    && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |->
    $past(wb_req_i.cyc && wb_req_i.stb)) else $error("stray ack");
  hop_range_a: assert property (hop_channel_o <= 3'h6)
    else $error("hop channel out of range");
  peer_match_a: assert property (rx_accept_o ==
    (rx_channel_i == hop_channel_o)) else $error("accept wrong");
  flow_code_a: assert property (flow_char_o.valid |->
    flow_char_o.data inside {8'h11, 8'h13}) else $error("bad char");
  flow_hold_a: assert property (flow_char_o.valid
    && !flow_char_ready_i |=> flow_char_o.valid
    && $stable(flow_char_o.data)) else $error("char dropped");
  radio_hold_a: assert property (radio_data_o.valid
    && !radio_data_ready_i |=> radio_data_o.valid
    && $stable(radio_data_o.data)) else $error("byte dropped");
  init_cause_a: assert property ($rose(initializer_send_o)
    |-> $past(tx_start_i)) else $error("initializer unprompted");
  // main scenarios seen
  cover property (wb_ack_o && !wb_req_i.we);
  cover property (flow_char_o.valid && flow_char_ready_i);
  cover property ($rose(initializer_send_o));
endmodule : host_flow_monitor

bind host_flow_and_wakeup_control host_flow_monitor host_flow_monitor_i (
  .clk_i, .rst_i, .wb_req_i, .wb_ack_o, .flow_char_o, .flow_char_ready_i,
  .radio_data_o, .radio_data_ready_i, .tx_start_i, .initializer_send_o,
  .rx_channel_i, .rx_accept_o, .hop_channel_o);

// File: host_serial_model.sv
// host model: sends serial bytes, takes flow characters
// assumes the device clock and a synchronous active-high reset
`timescale 1ns/100ps
module host_serial_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench controls
  input wire logic enable_i,
  input wire logic stall_i,
  // serial bytes toward the device
  input wire logic clear_to_send_i,
  input wire logic ready_i,
  output flow_wake_pkg::byte_stream_t serial_o,
  // flow characters from the device
  input wire flow_wake_pkg::byte_stream_t flow_char_i,
  output logic flow_char_ready_o
);
  import flow_wake_pkg::*;
  logic [7:0] nxt;
  logic paused;
  logic send_next;
  // a gap cycle after each byte lets clear-to-send settle
  always_comb begin
    send_next = (serial_o.valid && !ready_i) ||
      (enable_i && clear_to_send_i && !paused && !serial_o.valid);
  end
  // idle data is inverted so a stale byte never looks current
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_o <= '0;
      nxt <= 8'h00;
      paused <= 1'b0;
      flow_char_ready_o <= 1'b0;
    end else begin
      if (serial_o.valid && ready_i) begin
        nxt <= nxt + 8'h01;
      end
      serial_o.valid <= send_next;
      serial_o.data <= send_next ? nxt : ~serial_o.data;
      if (flow_char_i.valid && flow_char_ready_o) begin
        paused <= (flow_char_i.data == 8'h13);
      end
      flow_char_ready_o <= !stall_i;
    end
  end
endmodule : host_serial_model

// File: host_flow_and_wakeup_control_bench.sv
// self-checking bench of the flow and wake-up block
// assumes the params header on the include path, short tick counts
`timescale 1ns/100ps
`include "flow_wake_params.svh"
module host_flow_and_wakeup_control_bench;
  import flow_wake_pkg::*;
  logic clk_i, rst_i, tx_start_i, rx_good_i, rx_activity_i, ack;
  logic radio_rdy, stall, enable, cts, srdy, fc_rdy, init_send, acc, awk;
  logic [2:0] rx_ch, hop;
  logic [7:0] exp_byte, v;
  logic [15:0] r;
  logic [31:0] rdat;
  logic [31:0] exp_q[$];
  logic [7:0] fc_q[$];
  wb_req_t wb_req;
  byte_stream_t ser, fc, radio;
  int mismatches, total_checks, len;
  // ----
  // design and host model
  // ----
  host_flow_and_wakeup_control #(.TICK_CYCLES(10), .DETECT_CYCLES(4),
    .LISTEN_CYCLES(8)) host_flow_and_wakeup_control_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .serial_input_i(ser), .serial_input_ready_o(srdy),
    .clear_to_send_pin_o(cts), .flow_char_o(fc),
    .flow_char_ready_i(fc_rdy), .radio_data_o(radio),
    .radio_data_ready_i(radio_rdy), .tx_start_i(tx_start_i),
    .tx_active_i(tx_start_i), .initializer_send_o(init_send),
    .rx_activity_i(rx_activity_i), .rx_good_i(rx_good_i),
    .rx_channel_i(rx_ch), .initializer_detect_i(init_send),
    .rx_accept_o(acc), .hop_channel_o(hop), .radio_awake_o(awk));
  host_serial_model host_serial_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .enable_i(enable), .stall_i(stall), .clear_to_send_i(cts),
    .ready_i(srdy), .serial_o(ser), .flow_char_i(fc),
    .flow_char_ready_o(fc_rdy));
  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] e);
    total_checks++;
    if (seen !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, e);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // a read notes its expected data for the monitor
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    if (!w) exp_q.push_back(d);
    while (!ack && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      stop_test();
    end
    wb_req <= '0;
    @(posedge clk_i);
  endtask : wb
  task automatic start(input logic e);
    tx_start_i <= 1'b1;
    @(posedge clk_i);
    tx_start_i <= 1'b0;
    @(negedge clk_i);
    check(init_send, e);
    @(posedge clk_i);
  endtask : start
  task automatic wait_end();
    len = 0;
    while (init_send && len < 200) begin
      @(posedge clk_i);
      len++;
    end
    if (len >= 200) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_end
  task automatic good(input logic [2:0] c);
    rx_ch <= c;
    rx_good_i <= 1'b1;
    rx_activity_i <= 1'b1;
    @(posedge clk_i);
    rx_good_i <= 1'b0;
    rx_activity_i <= 1'b0;
    @(negedge clk_i);
    check(acc, c == hop);
    @(posedge clk_i);
  endtask : good
  // ----
  // clock and result monitor
  // ----
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // results compared in noted order
  always @(posedge clk_i) begin
    if (ack && !wb_req.we) begin
      check(rdat, exp_q.size() ? exp_q.pop_front() : ~rdat);
    end
    if (fc.valid && fc_rdy) begin
      check(fc.data, fc_q.size() ? fc_q.pop_front() : 8'h00);
    end
    if (radio.valid && radio_rdy) begin
      check(radio.data, exp_byte);
      exp_byte <= exp_byte + 8'h01;
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    rst_i = 1'b1;
    wb_req = '0;
    tx_start_i = 1'b0;
    rx_good_i = 1'b0;
    rx_activity_i = 1'b0;
    rx_ch = 3'h0;
    radio_rdy = 1'b0;
    stall = 1'b0;
    enable = 1'b0;
    exp_byte = 8'h00;
    mismatches = 0;
    total_checks = 0;
    v = 8'($urandom(32'h5e4c));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, `REG_CTRL, 32'h0);
    wb(0, `REG_THRESHOLD, 32'(`THRESHOLD_MAX));
    wb(0, `REG_GOOD_COUNT, 32'h0);
    wb(0, `REG_HOP, 32'h0);
    wb(0, `REG_IDLE_INIT, 32'(`IDLE_INIT_RESET));
    wb(0, 8'h24, 32'h0);
    repeat (60) @(posedge clk_i);
    start(0);
    wb(1, `REG_SLEEP_INT, 32'h3);
    wb(1, `REG_CTRL, 32'h2);
    start(1);
    wait_end();
    check(32'(len > 30), 32'h1);
    wb(0, `REG_CTRL, 32'h0);
    wb(1, `REG_IDLE_INIT, 32'h14);
    repeat (215) @(posedge clk_i);
    start(1);
    wait_end();
    start(0);
    wb(1, `REG_HOP, 32'h7);
    wb(0, `REG_HOP, 32'h0);
    wb(1, `REG_HOP, 32'h5);
    wb(0, `REG_HOP, 32'h5);
    len = 0;
    repeat (10) begin
      v = 8'($urandom_range(7, 0));
      good(v[2:0]);
      if (v == 8'h05) len++;
    end
    wb(0, `REG_GOOD_COUNT, 32'(len));
    wb(1, `REG_GOOD_COUNT, 32'hfffe);
    repeat (3) good(3'h5);
    wb(0, `REG_GOOD_COUNT, 32'hffff);
    r = 16'($urandom());
    wb(1, `REG_GOOD_COUNT, {16'h0000, r});
    wb(0, `REG_GOOD_COUNT, {16'h0000, r});
    wb(1, `REG_THRESHOLD, 32'hef);
    wb(0, `REG_THRESHOLD, 32'(`THRESHOLD_MAX));
    wb(1, `REG_THRESHOLD, 32'h3);
    enable <= 1'b1;
    repeat (20) @(posedge clk_i);
    wb(0, `REG_STATUS, 32'h38);
    enable <= 1'b0;
    repeat (30) begin
      radio_rdy <= 1'($urandom_range(1, 0));
      @(posedge clk_i);
    end
    radio_rdy <= 1'b1;
    repeat (8) @(posedge clk_i);
    wb(0, `REG_STATUS, 32'h09);
    radio_rdy <= 1'b0;
    wb(1, `REG_CTRL, 32'h1);
    wb(1, `REG_THRESHOLD, 32'h2);
    fc_q.push_back(8'h13);
    fc_q.push_back(8'h11);
    stall <= 1'b1;
    enable <= 1'b1;
    repeat (20) @(posedge clk_i);
    check(srdy, 32'h0);
    check({cts, awk}, 32'h3);
    stall <= 1'b0;
    repeat (10) @(posedge clk_i);
    radio_rdy <= 1'b1;
    repeat (20) @(posedge clk_i);
    enable <= 1'b0;
    repeat (10) @(posedge clk_i);
    check(32'(fc_q.size()), 32'h0);
    stop_test();
  end
endmodule : host_flow_and_wakeup_control_bench
